// ===== verilog/fsp_pkg.sv
// fsp_pkg: constants and types of the flash self-program sequencer
package fsp_pkg;
  // ---------------------------------------------------------------
  // register map, byte addresses on the bus
  // ---------------------------------------------------------------
  localparam int ADR_W = 6;
  localparam logic [5:0] ADR_CTRL = 6'h00;
  localparam logic [5:0] ADR_KEY = 6'h04;
  localparam logic [5:0] ADR_TPAGE = 6'h08;
  localparam logic [5:0] ADR_TEA = 6'h0C;
  localparam logic [5:0] ADR_TDATA = 6'h10;
  localparam logic [5:0] ADR_VPAGE = 6'h14;
  localparam logic [5:0] ADR_VEA = 6'h18;
  localparam logic [5:0] ADR_TADDR = 6'h1C;
  localparam logic [5:0] ADR_VADDR = 6'h20;
  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_ESIZE_LO = 0;
  localparam int CTRL_ERASE_BIT = 4;
  localparam int CTRL_WORD_BIT = 5;
  localparam int CTRL_TARGET_BIT = 8;
  localparam int CTRL_START_BIT = 15;
  localparam logic [1:0] ESIZE_1ROW = 2'h0;
  localparam logic [1:0] ESIZE_2ROW = 2'h1;
  localparam logic [1:0] ESIZE_4ROW = 2'h2;
  // ---------------------------------------------------------------
  // unlock keys, pages, geometry, timing
  // ---------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] VIS_PAGE_PROG = 8'h00;
  localparam logic [7:0] VIS_PAGE_EEPROM = 8'hFF;
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 96;
  localparam int IDX_W = 5;
  localparam int WORD_W = 24;
  localparam int ROW_W = 18;
  localparam int LAT_WR_CYCLES = 2;
  localparam logic [IDX_W-1:0] IDX_LAST = 5'h1F;

  typedef enum logic [2:0] {
    FSP_IDLE,
    FSP_PROG,
    FSP_PWAIT,
    FSP_ERASE,
    FSP_EWAIT
  } fsp_state_t;
endpackage : fsp_pkg

// ===== verilog/fsp_latch_bank.sv
// fsp_latch_bank: row-wide holding latches loaded by table writes
`timescale 1ns/100ps
`default_nettype none
module fsp_latch_bank
  import fsp_pkg::*;
#(
  parameter int WORDS = ROW_WORDS,
  parameter int WIDTH = WORD_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic we,
  input wire logic [$clog2(WORDS)-1:0] widx,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(WORDS)-1:0] ridx,
  output logic [WIDTH-1:0] rdata
);
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
  } fsp_lat_t;

  fsp_lat_t lat_q;
  fsp_lat_t lat_d;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // any order, last load to a slot wins; flash is untouched here
  // RULE_07 last load wins
  always_comb begin
    lat_d = lat_q;
    if (we) begin
      lat_d.mem[widx] = wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lat_q <= '0;
    end else begin
      lat_q <= lat_d;
    end
  end

  assign rdata = lat_q.mem[ridx];
endmodule : fsp_latch_bank
`default_nettype wire

// ===== verilog/fsp_sequencer.sv
// fsp_sequencer: run-time self-program sequencer with wishbone registers
//
// Local design decisions: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE_01: flash rows hold 32 instruction words, 96 bytes each.
// RULE_02: erase covers one, two or four rows per operation.
// RULE_03: program writes one full row, or one single word.
// RULE_04: erase and row blocks are aligned to their own size.
// RULE_05: table writes only load holding latches, flash unchanged until run.
// RULE_06: any latch count programs; a full row needs 32 table writes.
// RULE_07: latches load in any order; a later load replaces earlier data.
// RULE_08: each latch load is one word finishing in two cycles.
// RULE_09: every row needs its own separately started programming operation.
// RULE_10: key register is write-only; 55h then AAh unlocks.
// RULE_11: control register picks erase size, memory target and starts.
// RULE_12: visibility address is page register plus address bits 14..0.
// RULE_13: visibility page 00 maps program flash, FF maps data EEPROM.
// RULE_14: table address is 8-bit page and 16-bit address; top bit config.
// RULE_15: start ignored unless both keys came directly before it.
// RULE_16: start bit begins the operation and clears itself when done.
// RULE_17: processor is stalled while an operation runs.
// RULE_18: processor runs two no-ops after setting the start bit.
module fsp_sequencer
  import fsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [ADR_W-1:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_wdat,
  output logic [31:0] wb_rdat,
  output logic wb_ack,
  output logic cpu_stall,
  output logic flash_prog,
  output logic flash_erase,
  output logic [WORD_W-1:0] flash_addr,
  output logic [WORD_W-1:0] flash_data,
  output logic [1:0] flash_rows,
  output logic flash_target,
  input wire logic flash_done,
  output logic [WORD_W-1:0] tbl_addr,
  output logic [WORD_W-1:0] vis_addr,
  output logic vis_eeprom
);
  typedef struct packed {
    fsp_state_t st;
    logic ack;
    logic lphase;
    logic [31:0] rdat;
    logic key55;
    logic unlk;
    logic start;
    logic [1:0] esize;
    logic erase;
    logic word;
    logic target;
    logic [7:0] tpage;
    logic [15:0] tea;
    logic [7:0] vpage;
    logic [15:0] vea;
    logic [IDX_W-1:0] idx;
    logic [ROW_W-1:0] row;
    logic stall;
    logic fprog;
    logic ferase;
    logic [WORD_W-1:0] faddr;
    logic [WORD_W-1:0] fdata;
    logic [1:0] frows;
    logic [WORD_W-1:0] taddr;
    logic [WORD_W-1:0] vaddr;
    logic veep;
  } fsp_regs_t;

  fsp_regs_t r_q;
  fsp_regs_t r_d;
  logic take;
  logic lat_take;
  logic lat_we;
  logic start_go;
  logic [31:0] ctrl_rd;
  logic [31:0] wv;
  logic [IDX_W-1:0] lat_ridx;
  logic [WORD_W-1:0] lat_rdata;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge for partial writes
  function automatic logic [31:0] fsp_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return m;
  endfunction : fsp_merge

  // size mapping; the spare code 3 falls back to one row
  function automatic logic [1:0] fsp_norm(input logic [1:0] es);
    return (es == ESIZE_2ROW || es == ESIZE_4ROW) ? es : ESIZE_1ROW;
  endfunction : fsp_norm

  // clear the low row bits so the block starts on its own size
  function automatic logic [ROW_W-1:0] fsp_align(input logic [ROW_W-1:0] row,
                                                 input logic [1:0] es);
    logic [ROW_W-1:0] a;
    case (fsp_norm(es))
      ESIZE_2ROW: a = {row[ROW_W-1:1], 1'b0};
      ESIZE_4ROW: a = {row[ROW_W-1:2], 2'h0};
      default: a = row;
    endcase
    return a;
  endfunction : fsp_align

  // ---------------------------------------------------------------
  // holding latches
  // ---------------------------------------------------------------
  // idle readback follows the table address, busy reads follow the stream
  assign lat_ridx = (r_q.st == FSP_IDLE) ? r_q.tea[5:1] : r_q.idx;

  fsp_latch_bank #(
    .WORDS(ROW_WORDS),
    .WIDTH(WORD_W)
  ) u_latch (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .we(lat_we),
    .widx(r_q.tea[5:1]),
    .wdata(r_q.rdat[WORD_W-1:0]),
    .ridx(lat_ridx),
    .rdata(lat_rdata)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.ack = 1'b0;
    r_d.fprog = 1'b0;
    r_d.ferase = 1'b0;
    start_go = 1'b0;
    lat_we = 1'b0;
    ctrl_rd = '0;
    ctrl_rd[CTRL_ESIZE_LO +: 2] = r_q.esize;
    ctrl_rd[CTRL_ERASE_BIT] = r_q.erase;
    ctrl_rd[CTRL_WORD_BIT] = r_q.word;
    ctrl_rd[CTRL_TARGET_BIT] = r_q.target;
    ctrl_rd[CTRL_START_BIT] = r_q.start;
    take = wb_cyc && wb_stb && !r_q.ack && !r_q.lphase;
    lat_take = take && wb_we && (wb_adr == ADR_TDATA);
    wv = '0;

    // RULE_12 visibility address
    // RULE_13 page FF flags eeprom
    r_d.vaddr = {1'b0, r_q.vpage, r_q.vea[14:0]};
    r_d.veep = (r_q.vpage == VIS_PAGE_EEPROM);
    // RULE_14 table address forming
    r_d.taddr = {r_q.tpage, r_q.tea};

    // RULE_08 second latch cycle
    // RULE_05 latch only, no flash
    if (r_q.lphase) begin
      r_d.lphase = 1'b0;
      r_d.ack = 1'b1;
      lat_we = (r_q.st == FSP_IDLE);
    end

    if (take) begin
      r_d.rdat = '0;
      if (!wb_we) begin
        // read mux; the key register is write-only and reads zero
        r_d.ack = 1'b1;
        case (wb_adr)
          ADR_CTRL: r_d.rdat = ctrl_rd;
          ADR_TPAGE: r_d.rdat[7:0] = r_q.tpage;
          ADR_TEA: r_d.rdat[15:0] = r_q.tea;
          ADR_TDATA: r_d.rdat[WORD_W-1:0] = lat_rdata;
          ADR_VPAGE: r_d.rdat[7:0] = r_q.vpage;
          ADR_VEA: r_d.rdat[15:0] = r_q.vea;
          ADR_TADDR: r_d.rdat[WORD_W-1:0] = r_q.taddr;
          ADR_VADDR: r_d.rdat[WORD_W:0] = {r_q.veep, r_q.vaddr};
          default: r_d.rdat = '0;
        endcase
      end else begin
        // RULE_15 other writes cancel unlock
        r_d.key55 = 1'b0;
        r_d.unlk = 1'b0;
        r_d.ack = !lat_take;
        r_d.lphase = lat_take;
        if (lat_take) begin
          // data parked in rdat until the second cycle loads it
          r_d.rdat = wb_wdat;
        end
        case (wb_adr)
          ADR_KEY: begin
            // RULE_10 key pair sequence
            if (wb_wdat[7:0] == KEY_FIRST) begin
              r_d.key55 = 1'b1;
            end else if (r_q.key55 && wb_wdat[7:0] == KEY_SECOND) begin
              r_d.unlk = 1'b1;
            end
          end
          ADR_CTRL: begin
            wv = fsp_merge(ctrl_rd, wb_wdat, wb_sel);
            if (r_q.st == FSP_IDLE) begin
              // RULE_11 size, target, start
              r_d.esize = wv[CTRL_ESIZE_LO +: 2];
              r_d.erase = wv[CTRL_ERASE_BIT];
              r_d.word = wv[CTRL_WORD_BIT];
              r_d.target = wv[CTRL_TARGET_BIT];
              // RULE_15 start needs unlock
              // RULE_10 keys gate start
              start_go = wv[CTRL_START_BIT] && r_q.unlk;
            end
          end
          ADR_TPAGE: begin
            wv = fsp_merge({24'h000000, r_q.tpage}, wb_wdat, wb_sel);
            r_d.tpage = wv[7:0];
          end
          ADR_TEA: begin
            wv = fsp_merge({16'h0000, r_q.tea}, wb_wdat, wb_sel);
            r_d.tea = wv[15:0];
          end
          ADR_VPAGE: begin
            wv = fsp_merge({24'h000000, r_q.vpage}, wb_wdat, wb_sel);
            r_d.vpage = wv[7:0];
          end
          ADR_VEA: begin
            wv = fsp_merge({16'h0000, r_q.vea}, wb_wdat, wb_sel);
            r_d.vea = wv[15:0];
          end
          default: ;
        endcase
      end
    end

    // RULE_16 start bit sets operation
    // RULE_17 stall raised with start
    if (start_go) begin
      r_d.start = 1'b1;
      r_d.stall = 1'b1;
      r_d.row = r_q.taddr[WORD_W-1:6];
      r_d.idx = wv[CTRL_WORD_BIT] ? r_q.tea[5:1] : '0;
      r_d.st = wv[CTRL_ERASE_BIT] ? FSP_ERASE : FSP_PROG;
    end

    // operation sequencer
    case (r_q.st)
      FSP_IDLE: ;
      FSP_ERASE: begin
        // RULE_02 one, two or four rows
        // RULE_04 block aligned to its size
        r_d.ferase = 1'b1;
        r_d.frows = fsp_norm(r_q.esize);
        r_d.faddr = {fsp_align(r_q.row, r_q.esize), 6'h00};
        r_d.st = FSP_EWAIT;
      end
      FSP_PROG: begin
        // RULE_01 one 32-word row
        // RULE_03 stream latches to flash
        r_d.fprog = 1'b1;
        r_d.faddr = {r_q.row, r_q.idx, 1'b0};
        r_d.fdata = lat_rdata;
        r_d.st = FSP_PWAIT;
      end
      FSP_PWAIT: begin
        if (flash_done) begin
          // RULE_06 full row, unloaded slots too
          // RULE_09 one row per start
          if (r_q.word || r_q.idx == IDX_LAST) begin
            r_d.st = FSP_IDLE;
            r_d.start = 1'b0;
            r_d.stall = 1'b0;
          end else begin
            r_d.idx = r_q.idx + 1'b1;
            r_d.st = FSP_PROG;
          end
        end
      end
      FSP_EWAIT: begin
        // RULE_16 start self-clears
        // RULE_17 stall released at end
        if (flash_done) begin
          r_d.st = FSP_IDLE;
          r_d.start = 1'b0;
          r_d.stall = 1'b0;
        end
      end
      default: r_d.st = FSP_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from the state flops
  assign wb_rdat = r_q.rdat;
  assign wb_ack = r_q.ack;
  assign cpu_stall = r_q.stall;
  assign flash_prog = r_q.fprog;
  assign flash_erase = r_q.ferase;
  assign flash_addr = r_q.faddr;
  assign flash_data = r_q.fdata;
  assign flash_rows = r_q.frows;
  assign flash_target = r_q.target;
  assign tbl_addr = r_q.taddr;
  assign vis_addr = r_q.vaddr;
  assign vis_eeprom = r_q.veep;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_ERASE_ALIGN: assert property ( // RULE_04
    r_q.ferase |-> (r_q.faddr[5:0] == 6'h00) &&
      (r_q.frows != ESIZE_2ROW || !r_q.faddr[6]) &&
      (r_q.frows != ESIZE_4ROW || r_q.faddr[7:6] == 2'h0))
    else $error("erase block not aligned");
  AST_ERASE_SIZE: assert property ( // RULE_02
    r_q.ferase |-> r_q.frows == fsp_norm(r_q.esize))
    else $error("erase size mismatch");
  AST_PROG_IN_ROW: assert property ( // RULE_01
    r_q.fprog |-> r_q.faddr[WORD_W-1:6] == r_q.row && r_q.faddr[0] == 1'b0)
    else $error("program word outside row");
  AST_LAT_TWO: assert property ( // RULE_08
    lat_take |=> !r_q.ack ##1 r_q.ack)
    else $error("latch write not two cycles");
  AST_LAT_NO_FLASH: assert property ( // RULE_05
    lat_we |-> !r_q.fprog && !r_q.ferase && r_q.st == FSP_IDLE)
    else $error("latch load touched flash");
  AST_START_KEYED: assert property ( // RULE_15
    $rose(r_q.start) |-> $past(r_q.unlk) && !r_q.unlk)
    else $error("start without key pair");
  AST_SELF_CLEAR: assert property ( // RULE_16
    (r_q.st == FSP_EWAIT && flash_done) |=> !r_q.start && r_q.st == FSP_IDLE)
    else $error("start bit not cleared");
  AST_STALL: assert property ( // RULE_17
    r_q.st != FSP_IDLE |-> r_q.stall && r_q.start)
    else $error("busy without stall");
  AST_ROW_END: assert property ( // RULE_06
    (r_q.st == FSP_PWAIT && flash_done && !r_q.word && r_q.idx != IDX_LAST)
      |=> r_q.st == FSP_PROG && r_q.idx == $past(r_q.idx) + 1'b1)
    else $error("row stream broken");
  AST_VIS_ADDR: assert property ( // RULE_12
    ##1 r_q.vaddr == {1'b0, $past(r_q.vpage), $past(r_q.vea[14:0])})
    else $error("visibility address wrong");
  AST_TBL_ADDR: assert property ( // RULE_14
    ##1 r_q.taddr == {$past(r_q.tpage), $past(r_q.tea)})
    else $error("table address wrong");

  COV_ERASE: cover property (r_q.st == FSP_EWAIT && flash_done);
  COV_ROW: cover property (r_q.st == FSP_PWAIT && flash_done && r_q.idx == IDX_LAST);
  COV_WORD: cover property (r_q.st == FSP_PWAIT && flash_done && r_q.word);
endmodule : fsp_sequencer
`default_nettype wire

// ===== test/fsp_flash_model.sv
// fsp_flash_model: behavioural flash array behind the sequencer
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  input wire logic flash_prog,
  input wire logic flash_erase,
  input wire logic [WORD_W-1:0] flash_addr,
  input wire logic [WORD_W-1:0] flash_data,
  input wire logic [1:0] flash_rows,
  output logic flash_done
);
  // ---------------------------------------------------------------
  // array image and counters, read by the bench
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] mem [0:127];
  int n_prog;
  int n_erase;
  logic [WORD_W-1:0] erase_addr;
  logic [1:0] erase_rows;
  logic [7:0] wait_q;

  // word store or erase record (address, rows) per pulse; erase leaves mem as it is
  // done comes no sooner than one cycle after the pulse, slow mode stretches it
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 8'h00;
      flash_done <= 1'b0;
      n_prog <= 0;
      n_erase <= 0;
    end else begin
      flash_done <= 1'b0;
      if (flash_prog || flash_erase) begin
        wait_q <= slow ? 8'h07 : 8'h01;
        if (flash_prog) begin
          mem[flash_addr[7:1]] <= flash_data;
          n_prog <= n_prog + 1;
        end else begin
          erase_addr <= flash_addr;
          erase_rows <= flash_rows;
          n_erase <= n_erase + 1;
        end
      end else if (wait_q == 8'h01) begin
        wait_q <= 8'h00;
        flash_done <= 1'b1;
      end else if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end
    end
  end
endmodule : fsp_flash_model
`default_nettype wire

// ===== test/tb.sv
// tb: self-checking bench for the flash self-program sequencer
`timescale 1ns/100ps
`default_nettype none
module tb
  import fsp_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] tp;
    logic [15:0] tea;
    logic [7:0] vp;
    logic [15:0] vea;
    logic [31:0] et;
    logic [31:0] ev;
  } fsp_vec_t;
  logic clk_sys, nrst, wb_cyc, wb_stb, wb_we, wb_ack, cpu_stall, slow;
  logic flash_prog, flash_erase, flash_target, flash_done, vis_eeprom;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [WORD_W-1:0] flash_addr, flash_data, tbl_addr, vis_addr;
  logic [1:0] flash_rows;
  int n_mismatch, num_checks, lat;
  // address construction cases: pages and effective addresses at their edges
  fsp_vec_t vecs [3] = '{
    {8'h00, 16'h1234, 8'h00, 16'h8ABC, 32'h0000_1234, 32'h0000_0ABC},
    {8'h80, 16'hFFFE, 8'hFF, 16'hFFFF, 32'h0080_FFFE, 32'h017F_FFFF},
    {8'h7F, 16'h0000, 8'h01, 16'h7FFF, 32'h007F_0000, 32'h0000_FFFF}};
  logic [WORD_W-1:0] ers_exp [3] = '{24'h0100C0, 24'h010080, 24'h010000};

  fsp_sequencer u_fsp_sequencer (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdat(wb_wdat),
    .wb_rdat(wb_rdat), .wb_ack(wb_ack), .cpu_stall(cpu_stall), .flash_prog(flash_prog),
    .flash_erase(flash_erase), .flash_addr(flash_addr), .flash_data(flash_data),
    .flash_rows(flash_rows), .flash_target(flash_target), .flash_done(flash_done),
    .tbl_addr(tbl_addr), .vis_addr(vis_addr), .vis_eeprom(vis_eeprom));
  fsp_flash_model u_fsp_flash_model (.clk_sys(clk_sys), .nrst(nrst), .slow(slow),
    .flash_prog(flash_prog), .flash_erase(flash_erase), .flash_addr(flash_addr),
    .flash_data(flash_data), .flash_rows(flash_rows), .flash_done(flash_done));

  always #5 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tmo(input string nm);
    n_mismatch++;
    $display("wrong value %s expected answer seen timeout", nm);
    final_report();
  endtask : tmo

  // classic cycle: hold everything until ack is sampled high, count edges
  task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (wb_ack !== 1'b1 && lat < 40);
    if (lat >= 40) tmo("wb_ack");
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rg(input logic [5:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rg

  // unlock pair directly followed by the start write
  task automatic start(input logic [31:0] ctl);
    wr(ADR_KEY, {24'h0, KEY_FIRST});
    wr(ADR_KEY, {24'h0, KEY_SECOND});
    wr(ADR_CTRL, ctl | 32'h8000);
    #1 chk("stall_at_start", 1, cpu_stall);
    repeat (2) @(posedge clk_sys);
    rg(ADR_CTRL);
    chk("start_bit_busy", 1, rd[CTRL_START_BIT]);
    for (int k = 0; k < 200 && rd[CTRL_START_BIT] !== 1'b0; k++) rg(ADR_CTRL);
    if (rd[CTRL_START_BIT] !== 1'b0) tmo("start_bit_clear");
    chk("stall_after", 0, cpu_stall);
  endtask : start

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    {wb_cyc, wb_stb, wb_we, slow} = 4'h0;
    wb_adr = 6'h00;
    wb_sel = 4'hF;
    wb_wdat = 32'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rg(ADR_CTRL);
    chk("ctrl_reset", 0, rd);
    wr(ADR_KEY, 32'h55);
    rg(ADR_KEY);
    chk("key_read", 0, rd);
    rg(6'h3C);
    chk("unmapped_read", 0, rd);
    $display("test reset done");
    foreach (vecs[j]) begin
      wr(ADR_TPAGE, {24'h0, vecs[j].tp});
      wr(ADR_TEA, {16'h0, vecs[j].tea});
      wr(ADR_VPAGE, {24'h0, vecs[j].vp});
      wr(ADR_VEA, {16'h0, vecs[j].vea});
      rg(ADR_TADDR);
      chk("table_addr", vecs[j].et, rd);
      chk("tbl_addr_pin", vecs[j].et, {8'h0, tbl_addr});
      rg(ADR_VADDR);
      chk("vis_addr", vecs[j].ev, rd);
      chk("vis_eeprom_pin", {31'h0, vecs[j].ev[24]}, {31'h0, vis_eeprom});
    end
    $display("test address table done");
    // latches loaded backwards, one slot rewritten
    wr(ADR_TPAGE, 32'h0);
    for (int k = 31; k >= 0; k--) begin
      wr(ADR_TEA, 32'h40 + 2 * k);
      wr(ADR_TDATA, 32'h00A5_0000 | k);
    end
    chk("latch_ack_cycles", 3, lat);
    wr(ADR_TEA, 32'h46);
    wr(ADR_TDATA, 32'h0012_3456);
    rg(ADR_TDATA);
    chk("latch_rewrite", 32'h0012_3456, rd);
    chk("no_flash_write", 0, u_fsp_flash_model.n_prog);
    $display("test latch load done");
    // start alone, then a key pair broken by another write
    wr(ADR_CTRL, 32'h8000);
    rg(ADR_CTRL);
    chk("start_without_keys", 0, rd[CTRL_START_BIT]);
    wr(ADR_KEY, 32'h55);
    wr(ADR_TPAGE, 32'h0);
    wr(ADR_KEY, 32'hAA);
    wr(ADR_CTRL, 32'h8000);
    rg(ADR_CTRL);
    chk("start_broken_pair", 0, rd[CTRL_START_BIT]);
    chk("no_prog_pulse", 0, u_fsp_flash_model.n_prog);
    $display("test unlock refusal done");
    start(32'h0);
    chk("row_words", 32, u_fsp_flash_model.n_prog);
    for (int k = 0; k < 32; k++) begin
      chk("row_word", (k == 3) ? 32'h0012_3456 : (32'h00A5_0000 | k),
          {8'h0, u_fsp_flash_model.mem[32 + k]});
    end
    $display("test row program done");
    slow <= 1'b1;
    wr(ADR_TEA, 32'h4A);
    wr(ADR_TDATA, 32'h0065_4321);
    start(32'h1 << CTRL_WORD_BIT);
    chk("word_count", 33, u_fsp_flash_model.n_prog);
    chk("word_data", 32'h0065_4321, {8'h0, u_fsp_flash_model.mem[37]});
    $display("test word program done");
    // erase sizes, address inside the fourth row of a four-row block
    wr(ADR_TPAGE, 32'h01);
    wr(ADR_TEA, 32'hE6);
    for (int es = 0; es < 3; es++) begin
      start((32'h1 << CTRL_ERASE_BIT) | es | ((es == 2) ? 32'h100 : 32'h0));
      chk("erase_count", es + 1, u_fsp_flash_model.n_erase);
      chk("erase_addr", {8'h0, ers_exp[es]}, {8'h0, u_fsp_flash_model.erase_addr});
      chk("erase_rows", es, {30'h0, u_fsp_flash_model.erase_rows});
      chk("target", (es == 2) ? 1 : 0, {31'h0, flash_target});
    end
    // spare size code falls back to a single row
    start((32'h1 << CTRL_ERASE_BIT) | 32'h3);
    chk("erase_spare_rows", 0, {30'h0, u_fsp_flash_model.erase_rows});
    chk("erase_spare_addr", 32'h0001_00C0, {8'h0, u_fsp_flash_model.erase_addr});
    chk("erase_no_prog", 33, u_fsp_flash_model.n_prog);
    $display("test erase done");
    // reset cuts a running erase: stall must be low in reset, control must read zero after it
    wr(ADR_KEY, {24'h0, KEY_FIRST});
    wr(ADR_KEY, {24'h0, KEY_SECOND});
    wr(ADR_CTRL, 32'h0000_8010);
    chk("stall_before_reset", 1, cpu_stall);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    chk("stall_in_reset", 0, cpu_stall);
    rg(ADR_CTRL);
    chk("ctrl_after_reset", 0, rd);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
